// ### core/tdmsp_pkg.sv
/*
  constants, register map and carrier types of the time-division multiplexed
  multiprocessor serial port.
  assumes: one 250 MHz core clock; every other party on the three-wire bus uses
  the same slot framing.
*/
// Summary of operation
// - several devices share the bus by turns; one slot may address any receiver set
// - drive bus_data_line only in slots whose slot_select bit 0-7 is one
// - one shared bidirectional clock line joins rx and tx clock pins
// - one shared bidirectional data line joins rx and tx data pins
// - bus_address_line tells which devices capture the word on the data line
// - data bits shift into rx_shift, full word is copied to rx_buffer
// - multiprocessing enabled hides rx_buffer from memory-mapped access
// - tx_buffer word is copied into tx_shift before serial sending
// - multiprocessing enabled hides tx_buffer from memory-mapped access
// - rx_irq_flag sets when rx_shift word is copied into rx_buffer
// - tx_irq_flag sets when tx_buffer word is copied into tx_shift
// - rx_tx_address low byte is own address, high byte the destination
// - destination address goes out serially on bus_address_line
// - rx_address_status reports address line state and slot timing position
// - mux_port_control behaves as std_port_control except bit 0
// - bit 0 of mux_port_control enables or disables multiprocessing
// - tx_shift sends its word one bit at a time on the data pin
package tdmsp_pkg;

  // ---------------------------------------------------------------
  // register map (word index on the memory-mapped port)
  // ---------------------------------------------------------------
  localparam int          REG_AW          = 3;
  localparam logic [2:0]  OFS_CTL         = 3'h0;
  localparam logic [2:0]  OFS_SLOT_SEL    = 3'h1;
  localparam logic [2:0]  OFS_RXTX_ADDR   = 3'h2;
  localparam logic [2:0]  OFS_RX_BUF      = 3'h3;
  localparam logic [2:0]  OFS_TX_BUF      = 3'h4;
  localparam logic [2:0]  OFS_RX_ADR_STAT = 3'h5;
  localparam logic [2:0]  OFS_IRQ_FLAG    = 3'h6;

  // mux_port_control fields
  localparam int          CTL_MP_EN       = 0;
  localparam int          CTL_CLK_MASTER  = 1;
  localparam int          CTL_TX_READY    = 4;
  localparam int          CTL_RX_READY    = 5;
  localparam int          CTL_OVERRUN     = 6;
  localparam logic [15:0] CTL_WR_MASK     = 16'h0003;
  // irq_flag_reg fields, write one to clear
  localparam int          IRQ_RX          = 0;
  localparam int          IRQ_TX          = 1;

  localparam logic [15:0] RST_CTL         = 16'h0000;
  localparam logic [15:0] RST_SLOT_SEL    = 16'h0000;
  localparam logic [15:0] RST_RXTX_ADDR   = 16'h0000;
  localparam logic [15:0] SLOT_SEL_MASK   = 16'h00FF;

  // ---------------------------------------------------------------
  // slot framing
  // ---------------------------------------------------------------
  localparam int          WORD_W          = 16;
  localparam int          ADDR_W          = 8;
  localparam int          NUM_SLOTS       = 8;
  localparam logic [3:0]  BIT_LAST        = 4'hF;
  localparam logic [3:0]  ADDR_FIRST_BIT  = 4'h1;
  localparam logic [3:0]  ADDR_LAST_BIT   = 4'h8;
  localparam logic [2:0]  SLOT_LAST       = 3'h7;

  // ---------------------------------------------------------------
  // timing: bus clock generated when this device is clock master
  // ---------------------------------------------------------------
  localparam int          MCLK_PERIOD_PS  = 4000;
  localparam int          BUS_CLK_NS      = 125;
  localparam int          BUS_HALF_CYC    = (BUS_CLK_NS * 1000) / (2 * MCLK_PERIOD_PS);

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic drv;
    logic oe;
  } tdmsp_pin_t;

  typedef struct packed {
    logic [4:0] zero;
    logic [2:0] slot;
    logic [3:0] bitpos;
    logic [1:0] pad;
    logic       start_seen;
    logic       addr_level;
  } tdmsp_adr_stat_t;

endpackage

// ### core/tdmsp_port.sv
/*
  time-division multiplexed serial port: slot timing, transmit and receive
  shift paths, receive word FIFO and the memory-mapped register set.
  assumes: the shared clock, data and address lines are resolved outside from
  the enables with a pull-up; all bus inputs are asynchronous to mclk.
*/
`timescale 1ns/10ps

// ---------------------------------------------------------------
// small word FIFO
// ---------------------------------------------------------------
module tdmsp_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire do_push = in_valid && in_ready;
  wire do_pop  = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ---------------------------------------------------------------
// port top
// ---------------------------------------------------------------
module tdmsp_port
  import tdmsp_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // memory-mapped register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_wdata,
  output logic [15:0]            reg_rdata,
  // word port used while multiprocessing hides the buffers
  output logic                   rx_word_valid,
  input  wire logic              rx_word_ready,
  output logic [WORD_W-1:0]      rx_word,
  input  wire logic              tx_word_valid,
  output logic                   tx_word_ready,
  input  wire logic [WORD_W-1:0] tx_word,
  // shared bus clock line (rx and tx clock pins joined outside)
  input  wire logic              bus_clock_line_i,
  output logic                   bus_clock_line_o,
  output logic                   bus_clock_line_oe,
  // shared data line (rx and tx data pins joined outside)
  input  wire logic              bus_data_line_i,
  output logic                   bus_data_line_o,
  output logic                   bus_data_line_oe,
  // shared address line
  input  wire logic              bus_address_line_i,
  output logic                   bus_address_line_o,
  output logic                   bus_address_line_oe
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [15:0]       ctl;
  logic [15:0]       slot_select;
  logic [15:0]       rx_tx_address;
  logic [WORD_W-1:0] rx_buffer;
  logic [WORD_W-1:0] tx_buffer;
  logic [WORD_W-1:0] rx_shift;
  logic [WORD_W-1:0] tx_shift;
  logic [ADDR_W-1:0] rx_adr_shift;
  logic [ADDR_W-1:0] tx_adr_shift;
  logic              rx_full;
  logic              tx_full;
  logic              rx_irq_flag;
  logic              tx_irq_flag;
  logic              overrun;
  logic              start_seen;
  logic [3:0]        bit_idx;
  logic [2:0]        slot_idx;
  logic              tx_active;
  tdmsp_pin_t        dat_pin;
  tdmsp_pin_t        adr_pin;
  logic              clk_div_out;
  logic [7:0]        div_cnt;
  logic [2:0]        clk_sync;
  logic [1:0]        dat_sync;
  logic [1:0]        adr_sync;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire mp_en      = ctl[CTL_MP_EN];
  wire clk_master = ctl[CTL_CLK_MASTER];
  wire [ADDR_W-1:0] own_rx_addr  = rx_tx_address[7:0];
  wire [ADDR_W-1:0] dest_tx_addr = rx_tx_address[15:8];

  wire wr_ctl   = reg_wr && (reg_addr == OFS_CTL);
  wire wr_sel   = reg_wr && (reg_addr == OFS_SLOT_SEL);
  wire wr_adr   = reg_wr && (reg_addr == OFS_RXTX_ADDR);
  wire wr_irq   = reg_wr && (reg_addr == OFS_IRQ_FLAG);
  // buffers leave the memory map while multiprocessing runs
  wire wr_txbuf = reg_wr && (reg_addr == OFS_TX_BUF) && !mp_en;
  wire rd_rxbuf = reg_rd && (reg_addr == OFS_RX_BUF) && !mp_en;

  // bus clock edges, seen only after the two-flop synchroniser
  wire clk_rise = clk_sync[1] && !clk_sync[2];
  wire clk_fall = !clk_sync[1] && clk_sync[2];
  wire dat_s    = dat_sync[1];
  wire adr_s    = adr_sync[1];

  wire [3:0] next_bit  = (bit_idx == BIT_LAST) ? 4'h0 : bit_idx + 4'h1;
  wire [2:0] next_slot = (bit_idx == BIT_LAST) ?
                         ((slot_idx == SLOT_LAST) ? 3'h0 : slot_idx + 3'h1) : slot_idx;
  wire slot_start = mp_en && clk_fall && (next_bit == 4'h0);

  // transmitter claims only its own slots, and only with a word waiting
  wire tx_load = slot_start && slot_select[next_slot] && tx_full;

  // word complete at the last rising edge of a slot; start bit driven low
  wire [WORD_W-1:0] rx_word_now = {rx_shift[WORD_W-2:0], dat_s};
  wire rx_match = start_seen && ((rx_adr_shift & own_rx_addr) != '0);
  wire rx_done  = mp_en && clk_rise && (bit_idx == BIT_LAST);
  wire rx_push  = rx_done && rx_match;

  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  wire rx_take  = fifo_out_valid && !rx_full;
  wire rx_drain = mp_en ? (rx_word_valid && rx_word_ready) : rd_rxbuf;
  wire tx_fill  = mp_en ? (tx_word_valid && tx_word_ready) : wr_txbuf;

  tdmsp_adr_stat_t adr_stat;
  assign adr_stat = '{zero: '0, slot: slot_idx, bitpos: bit_idx, pad: '0,
                      start_seen: start_seen, addr_level: adr_s};

  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      OFS_CTL: begin
        // std_port_control layout with bit 0 taken by the enable
        rd_mux = ctl;
        rd_mux[CTL_TX_READY] = !tx_full;
        rd_mux[CTL_RX_READY] = rx_full;
        rd_mux[CTL_OVERRUN]  = overrun;
      end
      OFS_SLOT_SEL:    rd_mux = slot_select;
      OFS_RXTX_ADDR:   rd_mux = rx_tx_address;
      OFS_RX_BUF:      rd_mux = mp_en ? 16'h0000 : rx_buffer;
      OFS_TX_BUF:      rd_mux = mp_en ? 16'h0000 : tx_buffer;
      OFS_RX_ADR_STAT: rd_mux = adr_stat;
      OFS_IRQ_FLAG:    rd_mux = {14'h0000, tx_irq_flag, rx_irq_flag};
      default:         rd_mux = 16'h0000;
    endcase
  end

  assign rx_word_valid       = mp_en && rx_full;
  assign rx_word             = rx_buffer;
  assign tx_word_ready       = mp_en && !tx_full;
  assign bus_clock_line_o    = clk_div_out;
  assign bus_clock_line_oe   = clk_master;
  assign bus_data_line_o     = dat_pin.drv;
  assign bus_data_line_oe    = dat_pin.oe;
  assign bus_address_line_o  = adr_pin.drv;
  assign bus_address_line_oe = adr_pin.oe;

  // ---------------------------------------------------------------
  // receive FIFO between rx_shift and rx_buffer
  // ---------------------------------------------------------------
  tdmsp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word_now),
    .out_valid (fifo_out_valid),
    .out_ready (!rx_full),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // synchronisers and clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_sync <= 3'h7;
      dat_sync <= 2'h3;
      adr_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[1:0], bus_clock_line_i};
      dat_sync <= {dat_sync[0], bus_data_line_i};
      adr_sync <= {adr_sync[0], bus_address_line_i};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt     <= 8'h00;
      clk_div_out <= 1'b1;
    end else if (div_cnt == 8'(BUS_HALF_CYC - 1)) begin
      div_cnt     <= 8'h00;
      clk_div_out <= !clk_div_out;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctl           <= RST_CTL;
      slot_select   <= RST_SLOT_SEL;
      rx_tx_address <= RST_RXTX_ADDR;
      reg_rdata     <= 16'h0000;
    end else begin
      if (wr_ctl) ctl <= reg_wdata & CTL_WR_MASK;
      if (wr_sel) slot_select <= reg_wdata & SLOT_SEL_MASK;
      if (wr_adr) rx_tx_address <= reg_wdata;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  // flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_irq_flag <= 1'b0;
      tx_irq_flag <= 1'b0;
      overrun     <= 1'b0;
    end else begin
      rx_irq_flag <= rx_take || (rx_irq_flag && !(wr_irq && reg_wdata[IRQ_RX]));
      tx_irq_flag <= tx_load || (tx_irq_flag && !(wr_irq && reg_wdata[IRQ_TX]));
      overrun     <= (rx_push && !fifo_in_ready) || (overrun && !wr_ctl);
    end
  end

  // ---------------------------------------------------------------
  // buffers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_buffer <= '0;
      tx_buffer <= '0;
      rx_full   <= 1'b0;
      tx_full   <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_buffer <= fifo_out_data;
        rx_full   <= 1'b1;
      end else if (rx_drain) begin
        rx_full <= 1'b0;
      end
      // a fill in the load cycle is refused by ready, so the loaded word is safe
      if (tx_fill && !tx_load) begin
        tx_buffer <= mp_en ? tx_word : reg_wdata;
        tx_full   <= 1'b1;
      end else if (tx_load) begin
        tx_full <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // slot timing and shift paths
  // ---------------------------------------------------------------
  // outputs change on falling edges, inputs are sampled on rising edges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_idx      <= BIT_LAST;
      slot_idx     <= SLOT_LAST;
      tx_active    <= 1'b0;
      tx_shift     <= '0;
      tx_adr_shift <= '0;
      dat_pin      <= '{drv: 1'b1, oe: 1'b0};
      adr_pin      <= '{drv: 1'b1, oe: 1'b0};
    end else if (!mp_en) begin
      // leaving multiprocessing mode releases the lines at once
      bit_idx   <= BIT_LAST;
      slot_idx  <= SLOT_LAST;
      tx_active <= 1'b0;
      dat_pin   <= '{drv: 1'b1, oe: 1'b0};
      adr_pin   <= '{drv: 1'b1, oe: 1'b0};
    end else if (clk_fall) begin
      bit_idx  <= next_bit;
      slot_idx <= next_slot;
      if (tx_load) begin
        tx_active    <= 1'b1;
        tx_shift     <= {tx_buffer[WORD_W-2:0], 1'b0};
        tx_adr_shift <= dest_tx_addr;
        dat_pin      <= '{drv: tx_buffer[WORD_W-1], oe: 1'b1};
        adr_pin      <= '{drv: 1'b0, oe: 1'b1};
      end else if (slot_start) begin
        tx_active <= 1'b0;
        dat_pin   <= '{drv: 1'b1, oe: 1'b0};
        adr_pin   <= '{drv: 1'b1, oe: 1'b0};
      end else if (tx_active) begin
        tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
        dat_pin  <= '{drv: tx_shift[WORD_W-1], oe: 1'b1};
        if (next_bit >= ADDR_FIRST_BIT && next_bit <= ADDR_LAST_BIT) begin
          tx_adr_shift <= {tx_adr_shift[ADDR_W-2:0], 1'b0};
          adr_pin      <= '{drv: tx_adr_shift[ADDR_W-1], oe: 1'b1};
        end else begin
          adr_pin <= '{drv: 1'b1, oe: 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_shift     <= '0;
      rx_adr_shift <= '0;
      start_seen   <= 1'b0;
    end else if (mp_en && clk_rise) begin
      rx_shift <= rx_word_now;
      if (bit_idx == 4'h0) begin
        start_seen <= !adr_s;
      end
      if (bit_idx >= ADDR_FIRST_BIT && bit_idx <= ADDR_LAST_BIT) begin
        rx_adr_shift <= {rx_adr_shift[ADDR_W-2:0], adr_s};
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_load;
    tx_load && slot_select[next_slot] && mp_en;
  endsequence
  sequence s_first_bit;
    dat_pin.oe && adr_pin.oe && !adr_pin.drv && tx_active && (bit_idx == 4'h0);
  endsequence

  a_tx_slot_gate: assert property (tx_load |-> s_load ##1 s_first_bit)
    else $error("transmit started outside an enabled slot");
  a_tx_msb_first: assert property (tx_load |=> dat_pin.drv == $past(tx_buffer[WORD_W-1]))
    else $error("first data bit is not the buffer msb");
  a_tx_flag_set: assert property (tx_load |=> tx_irq_flag && !tx_full)
    else $error("transmit flag not set on shift load");
  a_rx_flag_set: assert property (rx_take |=> rx_irq_flag && rx_full && rx_buffer == $past(fifo_out_data))
    else $error("receive flag or buffer wrong after copy");
  a_rx_word_match: assert property (rx_push |-> rx_match && bit_idx == BIT_LAST && clk_rise)
    else $error("word captured without full word or address match");
  a_rx_buf_hidden: assert property (reg_rd && reg_addr == OFS_RX_BUF && mp_en |=> reg_rdata == 16'h0000)
    else $error("receive buffer visible in multiprocessing mode");
  a_tx_buf_hidden: assert property (reg_wr && reg_addr == OFS_TX_BUF && mp_en && !tx_word_valid && !tx_full |=> !tx_full)
    else $error("transmit buffer written in multiprocessing mode");
  a_mp_enable_bit: assert property (wr_ctl |=> mp_en == $past(reg_wdata[CTL_MP_EN]))
    else $error("enable bit does not follow control write");
  a_mp_off_quiet: assert property (!mp_en |=> !dat_pin.oe && !adr_pin.oe)
    else $error("bus driven while multiprocessing disabled");
  a_tx_refill: assert property (tx_load ##1 (mp_en && tx_word_valid) |-> tx_word_ready ##1 tx_full)
    else $error("transmit buffer refused a word during shifting");

endmodule

// ### sim/tdmsp_partner.sv
/*
  far-side device on the shared three-wire bus: makes the bus clock for whole
  frames, sends one word in one slot and captures every slot.
  assumes: lines resolved outside with pull-ups; the bench pulses go.
*/
`timescale 1ns/10ps
module tdmsp_partner (
  // resolved lines
  input  wire logic        data_l,
  input  wire logic        addr_l,
  // frame request
  input  wire logic        go,
  input  wire logic [2:0]  snd_slot,
  input  wire logic [15:0] snd_word,
  input  wire logic [7:0]  snd_addr,
  // line drives
  output logic             clk_o,
  output logic             clk_oe,
  output logic             dat_o,
  output logic             dat_oe,
  output logic             adr_o,
  output logic             adr_oe,
  // captures
  output logic [7:0][15:0] cap_data,
  output logic [7:0][7:0]  cap_addr,
  output logic [7:0]       cap_start,
  output logic [3:0]       nfr
);
  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  initial begin
    {clk_o, clk_oe, dat_o, dat_oe, adr_o, adr_oe} = 6'h2A;
    nfr = 4'h0;
  end
  // clock stands high between frames, so no stray edge reaches the port
  always begin
    @(posedge go);
    clk_oe = 1'b1;
    for (int s = 0; s < 8; s++) begin
      for (int b = 0; b < 16; b++) begin
        clk_o = 1'b0;
        dat_oe = (s == snd_slot);
        dat_o = snd_word[15-b];
        adr_oe = dat_oe && b < 9;
        adr_o = (b == 0) ? 1'b0 : snd_addr[3'(8 - b)];
        #62.5;
        clk_o = 1'b1;
        cap_data[s] = {cap_data[s][14:0], data_l};
        if (b == 0) begin
          cap_start[s] = addr_l;
        end else if (b < 9) begin
          cap_addr[s] = {cap_addr[s][6:0], addr_l};
        end
        #62.5;
      end
    end
    {dat_oe, adr_oe, clk_oe} = 3'h0;
    nfr = nfr + 4'h1;
  end
endmodule

// ### sim/tdmsp_port_tb.sv
/*
  self-checking bench of the multiplexed serial port against one far device.
  assumes: the port is not clock master; the partner clocks the bus.
*/
`timescale 1ns/10ps
module tdmsp_port_tb
  import tdmsp_pkg::*;
;
  logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, go = 0, rd_pend = 0;
  logic rx_word_ready = 1, tx_word_valid = 0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, tx_word = '0, p_word = '0, reg_rdata, rx_word, w;
  logic [7:0] own = 8'h04, dest, p_addr = '0;
  logic rx_word_valid, tx_word_ready, dc_o, dc_oe, dd_o, dd_oe, da_o, da_oe;
  logic pc_o, pc_oe, pd_o, pd_oe, pa_o, pa_oe;
  logic [7:0][15:0] cap_data;
  logic [7:0][7:0] cap_addr;
  logic [7:0] cap_start;
  logic [3:0] nfr;
  logic [15:0] exp_q[$];
  int seed = 32'h3654, miscompares = 0, cmp_count = 0;
  wire clk_l = (dc_oe ? dc_o : 1'b1) & (pc_oe ? pc_o : 1'b1);
  wire dat_l = (dd_oe ? dd_o : 1'b1) & (pd_oe ? pd_o : 1'b1);
  wire adr_l = (da_oe ? da_o : 1'b1) & (pa_oe ? pa_o : 1'b1);

  tdmsp_port #(.FIFO_DEPTH(4)) u_tdmsp_port (.mclk(mclk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
    .rx_word(rx_word), .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
    .tx_word(tx_word), .bus_clock_line_i(clk_l), .bus_clock_line_o(dc_o),
    .bus_clock_line_oe(dc_oe), .bus_data_line_i(dat_l), .bus_data_line_o(dd_o),
    .bus_data_line_oe(dd_oe), .bus_address_line_i(adr_l), .bus_address_line_o(da_o),
    .bus_address_line_oe(da_oe));
  tdmsp_partner u_tdmsp_partner (.data_l(dat_l), .addr_l(adr_l), .go(go),
    .snd_slot(3'h5), .snd_word(p_word), .snd_addr(p_addr), .clk_o(pc_o), .clk_oe(pc_oe),
    .dat_o(pd_o), .dat_oe(pd_oe), .adr_o(pa_o), .adr_oe(pa_oe), .cap_data(cap_data),
    .cap_addr(cap_addr), .cap_start(cap_start), .nfr(nfr));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  initial forever #2 mclk = ~mclk;
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // an empty queue means an unexpected result, so compare against its inverse
  task automatic take(input logic [15:0] seen);
    chk(seen, (exp_q.size() > 0) ? exp_q.pop_front() : ((^seen === 1'bx) ? 16'h0000 : ~seen));
  endtask
  always @(posedge mclk) begin
    if (rd_pend) take(reg_rdata);
    if (rx_word_valid === 1'b1 && rx_word_ready) take(rx_word);
    rd_pend = reg_rd;
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic frame(input logic [3:0] k);
    int n;
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; nfr !== k && n < 9000; n++) @(posedge mclk);
    if (n == 9000) begin
      miscompares++;
      finish_test();
    end
  endtask

  initial begin
    int n;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    dest = 8'($random(seed)) & 8'hFB;
    w = 16'($random(seed));
    rd(3'h0, 16'h0010);
    wr(3'h1, 16'hFFFF);
    rd(3'h1, 16'h00FF);
    wr(3'h1, 16'h0004);
    wr(3'h2, {dest, own});
    rd(3'h2, {dest, own});
    rd(3'h7, 16'h0000);
    rd(3'h5, 16'h07F1);
    wr(3'h0, 16'h0001);
    rd(3'h0, 16'h0011);
    rd(3'h3, 16'h0000);
    rd(3'h4, 16'h0000);
    @(posedge mclk);
    tx_word <= w;
    tx_word_valid <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (tx_word_ready === 1'b1) break;
    end
    if (n == 200) begin
      miscompares++;
      finish_test();
    end
    tx_word_valid <= 1'b0;
    @(posedge mclk);
    chk({15'h0, tx_word_ready}, 16'h0000);
    p_word <= 16'($random(seed));
    p_addr <= 8'($random(seed)) | own;
    @(posedge mclk);
    exp_q.push_back(p_word);
    frame(4'h1);
    chk(cap_data[2], w);
    chk({cap_start[2], 7'h0, cap_addr[2]}, {8'h00, dest});
    chk(cap_data[0], 16'hFFFF);
    chk({15'h0, dc_oe}, 16'h0000);
    wr(3'h4, 16'hA5A5);
    @(posedge mclk);
    chk({15'h0, tx_word_ready}, 16'h0001);
    rd(3'h6, 16'h0003);
    wr(3'h6, 16'h0003);
    rd(3'h6, 16'h0000);
    rd(3'h3, 16'h0000);
    rd(3'h4, 16'h0000);
    p_addr <= 8'($random(seed)) & 8'hFB;
    frame(4'h2);
    chk(cap_data[2], 16'hFFFF);
    repeat (20) @(posedge mclk);
    chk(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule
